// ---- hw/gcwf_pkg.sv ----
/*
 Shared constants for the general purpose pin block: pin configuration
 codes, device register indices, host register offsets, timing counts.
 Assumes a single 25 MHz clock shared by both ends.
*/
package gcwf_pkg;
   // ==========================================================
   // Pins and configuration codes
   localparam int NPIN = 9;
   localparam int NANA = 7;
   localparam int SYNC_W = 12;
   localparam logic [1:0] CFG_ANA = 2'h0;
   localparam logic [1:0] CFG_DOUT = 2'h1;
   localparam logic [1:0] CFG_DIN = 2'h2;
   localparam logic [1:0] CFG_OFF = 2'h3;
   // Pin 1 din, pin 2 dout, pins 3-6 analog, pin 7 din, pins 8-9 analog
   localparam logic [17:0] CFG_RESET = 18'h02006;

   // ==========================================================
   // Device register indices (word addresses on the link port)
   localparam logic [3:0] DREG_CFG = 4'h0;
   localparam logic [3:0] DREG_OUT = 4'h1;
   localparam logic [3:0] DREG_IN = 4'h2;
   localparam logic [3:0] DREG_CTRL = 4'h3;
   localparam logic [3:0] DREG_STAT = 4'h4;
   localparam logic [3:0] DREG_RES0 = 4'h8;
   localparam int CTRL_WAKE_EN = 0;
   localparam int CTRL_RATIO = 1;
   localparam logic [1:0] CTRL_RESET = 2'h0;
   localparam logic [8:0] OUT_RESET = 9'h000;
   localparam int STAT_LP = 0;
   localparam int STAT_FAULT = 1;
   localparam int STAT_WAKE = 2;
   localparam int STAT_SEL = 3;
   localparam int RES_MODE_BIT = 31;

   // ==========================================================
   // Conversion scaling
   localparam int ABS_LSB_UV = 89;
   localparam int RATIO_LSB_EXP = 16;

   // ==========================================================
   // Timing
   localparam int CLK_NS = 40;
   localparam int WAKE_FILTER_NS = 20000;
   localparam int WAKE_FILTER_CYC = (WAKE_FILTER_NS + CLK_NS - 1) / CLK_NS;
   localparam int WAKE_CNT_W = 10;

   // ==========================================================
   // Host register byte offsets
   localparam logic [11:0] HREG_DEV_ADDR = 12'h000;
   localparam logic [11:0] HREG_DEV_WDATA = 12'h004;
   localparam logic [11:0] HREG_DEV_CMD = 12'h008;
   localparam logic [11:0] HREG_DEV_RDATA = 12'h00c;
   localparam logic [11:0] HREG_IRQ_STAT = 12'h010;
   localparam logic [11:0] HREG_IRQ_CLR = 12'h014;
   localparam logic [11:0] HREG_IRQ_EN = 12'h018;
   localparam logic [11:0] HREG_EXT_OUT = 12'h01c;
   localparam logic [11:0] HREG_EXT_OE = 12'h020;
   localparam logic [11:0] HREG_STRAP = 12'h024;
   localparam logic [11:0] HREG_PINS = 12'h028;
   localparam int CMD_GO = 0;
   localparam int CMD_WRITE = 1;
   localparam int IRQ_FAULT = 0;
   localparam int IRQ_DONE = 1;
   localparam logic [2:0] STRAP_RESET = 3'h2;
endpackage

// ---- hw/gcwf_link_if.sv ----
/*
 Link between the monitor device end and the host end: nine pins as
 output and enable per party, straps, isolated pins and a word register
 port. Assumes both ends run on the same clock.
*/
`timescale 1ns/100ps
`default_nettype none
interface gcwf_link_if;
   logic [8:0] pin_lvl;
   logic [8:0] dev_o;
   logic [8:0] dev_oe;
   logic [8:0] ext_o;
   logic [8:0] ext_oe;
   logic serial_port_select;
   logic isolated_neg_pin;
   logic isolated_pos_pin;
   logic reg_req;
   logic reg_wr;
   logic [3:0] reg_addr;
   logic [31:0] reg_wdata;
   logic [31:0] reg_rdata;
   logic reg_ack;

   // Device wins a contested pin; an undriven pin reads low
   assign pin_lvl = (dev_oe & dev_o) | (~dev_oe & ext_oe & ext_o);

   modport dev (
      input pin_lvl, serial_port_select, isolated_neg_pin, isolated_pos_pin,
      input reg_req, reg_wr, reg_addr, reg_wdata,
      output dev_o, dev_oe, reg_rdata, reg_ack
   );
   modport host (
      input pin_lvl, reg_rdata, reg_ack,
      output ext_o, ext_oe, serial_port_select, isolated_neg_pin, isolated_pos_pin,
      output reg_req, reg_wr, reg_addr, reg_wdata
   );
endinterface
`default_nettype wire

// ---- hw/gcwf_device.sv ----
/*
 Monitor device end of the pin block: per-pin configuration, digital
 in/out, fault relay, wake filter and sleep gating, serial pin routing
 and analog result capture. Assumes an ADC that returns codes per pin
 and a power manager that issues sleep and timeout pulses.
*/
// Local design decisions: the register offsets and the APB interface to the registers.
`timescale 1ns/100ps
`default_nettype none
// Function
// - Nine pins, each digital or analog alone
// - Only pins 3-9 are analog conversion inputs
// - Fault on 1-2, wake 7, serial 8-9
// - Pins 1,2 locked din/dout
// - Defaults; pins 8,9 locked when serial selected
// - Result absolute or ratio by select bit
// - Ratio change leaves thresholds alone
// - Host checks divider at startup
// - Digital pin is input or driven output
// - Serial select: pin8 clock, pin9 data out
// - Wake needs din config and enable bit
// - Filtered high pin 7 wakes device
// - High pin 7 blocks sleep and timeout
// - Sleep only when pin 7 low
// - Pin 1 senses fault, pin 2 relays
// - Host may use fault out as interrupt
// - Absolute step 89 uV, ratio 2^-16
module gcwf_device
   import gcwf_pkg::*;
(
   // Clock and reset
   input wire logic clk,
   input wire logic reset_n,
   // Link to host and chain
   gcwf_link_if.dev lnk,
   // Power manager
   input wire logic sleep_command,
   input wire logic comm_timeout,
   output logic low_power,
   // Local fault source
   input wire logic local_fault,
   // Analog conversion
   output logic [6:0] conv_mask,
   input wire logic conv_valid,
   input wire logic [2:0] conv_pin,
   input wire logic [15:0] conv_code,
   // Serial port core
   output logic spi_active,
   output logic spi_sck,
   output logic spi_cs_n,
   output logic spi_sdi,
   input wire logic spi_sdo
);
   // ==========================================================
   // Helpers
   // Two-bit field of pin p (zero based)
   function automatic logic [1:0] pin_cfg(input logic [17:0] c, input int p);
      return c[2*p +: 2];
   endfunction

   // Locked pins override the stored fields
   function automatic logic [17:0] lock_cfg(input logic [17:0] c, input logic sel);
      logic [17:0] r;
      r = c;
      r[1:0] = CFG_DIN;
      r[3:2] = CFG_DOUT;
      if (sel) begin
         r[15:14] = CFG_DIN;
         r[17:16] = CFG_DOUT;
      end
      return r;
   endfunction

   // Scale a code: microvolts in absolute mode, 16-bit fraction in ratio mode
   function automatic logic [31:0] scale(input logic [15:0] code, input logic ratio);
      logic [22:0] uv;
      uv = 23'(code) * 23'(ABS_LSB_UV);
      if (ratio) begin
         return {1'b1, 15'h0000, code};
      end
      return {1'b0, 8'h00, uv};
   endfunction

   // ==========================================================
   // Input synchronisers
   logic [SYNC_W-1:0] sync1_q;
   logic [SYNC_W-1:0] sync2_q;
   logic [8:0] pins_s;
   logic sel_s;
   logic iso_neg_s;
   logic iso_pos_s;

   // Pins and straps come from outside; only stage two is read
   always_ff @(posedge clk or negedge reset_n) begin
      if (!reset_n) begin
         sync1_q <= '0;
         sync2_q <= '0;
      end else begin
         sync1_q <= {lnk.serial_port_select, lnk.isolated_pos_pin, lnk.isolated_neg_pin,
                     lnk.pin_lvl};
         sync2_q <= sync1_q;
      end
   end
   assign pins_s = sync2_q[8:0];
   assign iso_neg_s = sync2_q[9];
   assign iso_pos_s = sync2_q[10];
   assign sel_s = sync2_q[11];

   // ==========================================================
   // Register port
   logic [17:0] cfg_q;
   logic [8:0] out_q;
   logic [1:0] ctrl_q;
   logic ack_q;
   logic [31:0] rdata_q;
   logic [31:0] res_q [NANA];
   logic [31:0] rd_mux;
   logic [17:0] eff_cfg;
   logic take;
   logic wr_take;
   logic [3:0] res_idx;
   logic lp_q;
   logic fault_q;
   logic sdo_q;
   logic [WAKE_CNT_W-1:0] wcnt_q;
   logic wake_active;
   logic wake_ok;
   logic keep_awake;

   assign eff_cfg = lock_cfg(cfg_q, sel_s);
   assign take = lnk.reg_req & ~ack_q;
   assign wr_take = take & lnk.reg_wr;
   assign res_idx = lnk.reg_addr - DREG_RES0;

   // Read selection; unmapped indices read zero
   always_comb begin
      rd_mux = 32'h0000_0000;
      case (lnk.reg_addr)
         DREG_CFG: rd_mux = {14'h0000, eff_cfg};
         DREG_OUT: rd_mux = {23'h000000, out_q};
         DREG_IN: rd_mux = {23'h000000, pins_s};
         DREG_CTRL: rd_mux = {30'h0000_0000, ctrl_q};
         DREG_STAT: rd_mux = {28'h0000000, sel_s, wake_ok, pins_s[0], lp_q};
         default: begin
            if (lnk.reg_addr >= DREG_RES0 && res_idx < 4'(NANA)) begin
               rd_mux = res_q[res_idx[2:0]];
            end
         end
      endcase
   end

   // Request taken once, answered one cycle later
   always_ff @(posedge clk or negedge reset_n) begin
      if (!reset_n) begin
         ack_q <= 1'b0;
         rdata_q <= 32'h0000_0000;
      end else begin
         ack_q <= take;
         if (take) begin
            rdata_q <= rd_mux;
         end
      end
   end
   assign lnk.reg_ack = ack_q;
   assign lnk.reg_rdata = rdata_q;

   // Writable registers; ratio change does not touch any threshold
   always_ff @(posedge clk or negedge reset_n) begin
      if (!reset_n) begin
         cfg_q <= CFG_RESET;
         out_q <= OUT_RESET;
         ctrl_q <= CTRL_RESET;
      end else if (wr_take) begin
         if (lnk.reg_addr == DREG_CFG) begin
            cfg_q <= lnk.reg_wdata[17:0];
         end
         if (lnk.reg_addr == DREG_OUT) begin
            out_q <= lnk.reg_wdata[8:0];
         end
         if (lnk.reg_addr == DREG_CTRL) begin
            ctrl_q <= lnk.reg_wdata[1:0];
         end
      end
   end

   // ==========================================================
   // Analog results
   // Codes for non-analog pins are dropped so stale pins keep old data
   always_ff @(posedge clk or negedge reset_n) begin
      if (!reset_n) begin
         for (int i = 0; i < NANA; i++) begin
            res_q[i] <= 32'h0000_0000;
         end
      end else if (conv_valid && conv_pin < 3'(NANA) && conv_mask[conv_pin]) begin
         res_q[conv_pin] <= scale(conv_code, ctrl_q[CTRL_RATIO]);
      end
   end

   // Only pins 3-9 can join the conversion routine
   always_comb begin
      for (int i = 0; i < NANA; i++) begin
         conv_mask[i] = pin_cfg(eff_cfg, i + 2) == CFG_ANA;
      end
   end

   // ==========================================================
   // Pin drivers
   always_ff @(posedge clk or negedge reset_n) begin
      if (!reset_n) begin
         fault_q <= 1'b0;
         sdo_q <= 1'b0;
      end else begin
         fault_q <= pins_s[0] | local_fault;
         sdo_q <= spi_sdo;
      end
   end

   // Driven only where the field selects a digital output
   always_comb begin
      for (int i = 0; i < NPIN; i++) begin
         lnk.dev_oe[i] = pin_cfg(eff_cfg, i) == CFG_DOUT;
      end
      lnk.dev_o = out_q;
      lnk.dev_o[1] = fault_q;
      if (sel_s) begin
         lnk.dev_o[8] = sdo_q;
      end
   end

   // Serial routing only when the device is the chain bottom
   assign spi_active = sel_s;
   assign spi_sck = sel_s & pins_s[7];
   assign spi_cs_n = ~sel_s | iso_neg_s;
   assign spi_sdi = sel_s & iso_pos_s;

   // ==========================================================
   // Wake and low power
   assign wake_active = ctrl_q[CTRL_WAKE_EN] & (pin_cfg(eff_cfg, 6) == CFG_DIN);
   assign keep_awake = wake_active & pins_s[6];
   assign wake_ok = wcnt_q == WAKE_CNT_W'(WAKE_FILTER_CYC);

   // Counter restarts on any low sample, so glitches never wake
   always_ff @(posedge clk or negedge reset_n) begin
      if (!reset_n) begin
         wcnt_q <= '0;
      end else if (!keep_awake) begin
         wcnt_q <= '0;
      end else if (!wake_ok) begin
         wcnt_q <= wcnt_q + 1'b1;
      end
   end

   // Sleep requests while pin 7 is high are dropped, not deferred
   always_ff @(posedge clk or negedge reset_n) begin
      if (!reset_n) begin
         lp_q <= 1'b0;
      end else if (lp_q) begin
         if (wake_ok) begin
            lp_q <= 1'b0;
         end
      end else if (!keep_awake && (sleep_command || comm_timeout)) begin
         lp_q <= 1'b1;
      end
   end
   assign low_power = lp_q;
endmodule
`default_nettype wire

// ---- hw/gcwf_host.sv ----
/*
 Host end of the pin block: APB slave for software, master of the
 device register port, drivers for straps and pins, and the fault and
 access-done interrupt. Assumes the device answers on the shared clock.
*/
`timescale 1ns/100ps
`default_nettype none
module gcwf_host
   import gcwf_pkg::*;
(
   // Clock and reset
   input wire logic clk,
   input wire logic reset_n,
   // Link to device
   gcwf_link_if.host lnk,
   // APB slave
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [11:0] paddr,
   input wire logic [31:0] pwdata,
   output logic [31:0] prdata,
   output logic pready,
   output logic pslverr,
   // Interrupt
   output logic irq
);
   // ==========================================================
   // State
   logic [3:0] addr_q;
   logic [31:0] wdata_q;
   logic req_q;
   logic wr_q;
   logic [31:0] drd_q;
   logic [1:0] ist_q;
   logic [1:0] ien_q;
   logic [8:0] eo_q;
   logic [8:0] eoe_q;
   logic [2:0] strap_q;
   logic [8:0] ps1_q;
   logic [8:0] ps2_q;
   logic fprev_q;
   logic [31:0] prdata_q;
   logic perr_q;
   logic irq_q;
   logic [31:0] rd_mux;
   logic mapped;
   logic setup;
   logic wr_en;
   logic [1:0] ev;

   // ==========================================================
   // APB decode; no wait states, data latched in the setup cycle
   assign setup = psel & ~penable;
   assign wr_en = psel & penable & pwrite;
   assign pready = 1'b1;
   assign prdata = prdata_q;
   assign pslverr = perr_q;
   assign mapped = paddr <= HREG_PINS && paddr[1:0] == 2'h0;

   // Read selection
   always_comb begin
      rd_mux = 32'h0000_0000;
      case (paddr)
         HREG_DEV_ADDR: rd_mux = {28'h0000000, addr_q};
         HREG_DEV_WDATA: rd_mux = wdata_q;
         HREG_DEV_CMD: rd_mux = {31'h0000_0000, req_q};
         HREG_DEV_RDATA: rd_mux = drd_q;
         HREG_IRQ_STAT: rd_mux = {30'h0000_0000, ist_q};
         HREG_IRQ_EN: rd_mux = {30'h0000_0000, ien_q};
         HREG_EXT_OUT: rd_mux = {23'h000000, eo_q};
         HREG_EXT_OE: rd_mux = {23'h000000, eoe_q};
         HREG_STRAP: rd_mux = {29'h0000_0000, strap_q};
         HREG_PINS: rd_mux = {23'h000000, ps2_q};
         default: rd_mux = 32'h0000_0000;
      endcase
   end

   // Answer registered during setup
   always_ff @(posedge clk or negedge reset_n) begin
      if (!reset_n) begin
         prdata_q <= 32'h0000_0000;
         perr_q <= 1'b0;
      end else if (setup) begin
         prdata_q <= pwrite ? 32'h0000_0000 : rd_mux;
         perr_q <= ~mapped;
      end
   end

   // Software registers
   always_ff @(posedge clk or negedge reset_n) begin
      if (!reset_n) begin
         addr_q <= 4'h0;
         wdata_q <= 32'h0000_0000;
         ien_q <= 2'h0;
         eo_q <= 9'h000;
         eoe_q <= 9'h000;
         strap_q <= STRAP_RESET;
      end else if (wr_en) begin
         case (paddr)
            HREG_DEV_ADDR: addr_q <= pwdata[3:0];
            HREG_DEV_WDATA: wdata_q <= pwdata;
            HREG_IRQ_EN: ien_q <= pwdata[1:0];
            HREG_EXT_OUT: eo_q <= pwdata[8:0];
            HREG_EXT_OE: eoe_q <= pwdata[8:0];
            HREG_STRAP: strap_q <= pwdata[2:0];
            default: ;
         endcase
      end
   end

   // ==========================================================
   // Device port master; a go while busy is ignored
   always_ff @(posedge clk or negedge reset_n) begin
      if (!reset_n) begin
         req_q <= 1'b0;
         wr_q <= 1'b0;
         drd_q <= 32'h0000_0000;
      end else if (req_q) begin
         if (lnk.reg_ack) begin
            req_q <= 1'b0;
            drd_q <= lnk.reg_rdata;
         end
      end else if (wr_en && paddr == HREG_DEV_CMD && pwdata[CMD_GO]) begin
         req_q <= 1'b1;
         wr_q <= pwdata[CMD_WRITE];
      end
   end
   assign lnk.reg_req = req_q;
   assign lnk.reg_wr = wr_q;
   assign lnk.reg_addr = addr_q;
   assign lnk.reg_wdata = wdata_q;
   assign lnk.ext_o = eo_q;
   assign lnk.ext_oe = eoe_q;
   assign lnk.serial_port_select = strap_q[0];
   assign lnk.isolated_neg_pin = strap_q[1];
   assign lnk.isolated_pos_pin = strap_q[2];

   // ==========================================================
   // Pin sampling and interrupt
   assign ev[IRQ_FAULT] = ps2_q[1] & ~fprev_q;
   assign ev[IRQ_DONE] = req_q & lnk.reg_ack;

   // Set beats clear in the same cycle so no event is lost
   always_ff @(posedge clk or negedge reset_n) begin
      if (!reset_n) begin
         ps1_q <= 9'h000;
         ps2_q <= 9'h000;
         fprev_q <= 1'b0;
         ist_q <= 2'h0;
         irq_q <= 1'b0;
      end else begin
         ps1_q <= lnk.pin_lvl;
         ps2_q <= ps1_q;
         fprev_q <= ps2_q[1];
         ist_q <= (ist_q & ~((wr_en && paddr == HREG_IRQ_CLR) ? pwdata[1:0] : 2'h0)) | ev;
         irq_q <= |(ist_q & ien_q);
      end
   end
   assign irq = irq_q;
endmodule
`default_nettype wire

// ---- testbench/gcwf_asserts.sv ----
/*
 Checker of the link between the device end and the host end.
 Assumes one clock for both ends and lnk signals as plain inputs.
*/
`timescale 1ns/100ps
`default_nettype none
module gcwf_asserts (
   // Clock and reset
   input wire logic clk,
   input wire logic reset_n,
   // Link signals
   input wire logic [8:0] pin_lvl,
   input wire logic [8:0] dev_o,
   input wire logic [8:0] dev_oe,
   input wire logic serial_port_select,
   input wire logic reg_req,
   input wire logic reg_ack
);
   // ==========================================================
   // Properties
   default clocking cb @(posedge clk); endclocking
   default disable iff (!reset_n);

   // Fault pins keep their direction whatever software writes
   pin_one_input_a: assert property (!dev_oe[0]) else $error("pin 1 driven");
   pin_two_out_a: assert property (dev_oe[1]) else $error("pin 2 released");
   // Two sync stages plus the relay flop
   fault_relay_a: assert property ($rose(pin_lvl[0]) |-> ##3 dev_o[1])
      else $error("fault not relayed");
   // Register port answers one cycle after the take
   ack_timing_a: assert property ($rose(reg_req) |-> ##1 reg_ack)
      else $error("ack late");
   ack_pulse_a: assert property (reg_ack |=> !reg_ack) else $error("ack too long");
   ack_cause_a: assert property (reg_ack |-> $past(reg_req))
      else $error("ack without request");
   req_release_a: assert property (reg_ack |=> !reg_req) else $error("request held");
   // Select needs its synchroniser to settle before the lock shows
   serial_lock_a: assert property (serial_port_select [*5] |-> !dev_oe[7] && dev_oe[8])
      else $error("serial pins not locked");

   cover property (reg_ack);
   cover property ($rose(dev_o[1]));
   cover property (serial_port_select && dev_oe[8]);
endmodule
`default_nettype wire

// ---- testbench/tb_gpio_config_wakeup_fault.sv ----
/*
 Testbench of the pin block: both ends joined by the link, software
 through APB. Assumes pready answers within a few cycles.
*/
`timescale 1ns/100ps
`default_nettype none
module tb_gpio_config_wakeup_fault;
   import gcwf_pkg::*;
   // ==========================================================
   // Signals
   logic clk = 1'h0;
   logic reset_n = 1'h0;
   logic psel = 1'h0;
   logic penable = 1'h0;
   logic pwrite = 1'h0;
   logic [11:0] paddr = 12'h000;
   logic [31:0] pwdata = 32'h0;
   logic [31:0] prdata, rd;
   logic pready, pslverr, irq, err;
   logic sleep_command = 1'h0;
   logic comm_timeout = 1'h0;
   logic local_fault = 1'h0;
   logic conv_valid = 1'h0;
   logic spi_sdo = 1'h0;
   logic [2:0] conv_pin = 3'h0;
   logic [15:0] conv_code = 16'h0000;
   logic low_power, spi_active, spi_sck, spi_cs_n, spi_sdi;
   logic [6:0] conv_mask;
   int error_cnt = 0;
   int total_checks = 0;
   int cyc = 0;

   gcwf_link_if lnk();
   gcwf_device i_gcwf_device (.clk(clk), .reset_n(reset_n), .lnk(lnk),
      .sleep_command(sleep_command), .comm_timeout(comm_timeout), .low_power(low_power),
      .local_fault(local_fault), .conv_mask(conv_mask), .conv_valid(conv_valid),
      .conv_pin(conv_pin), .conv_code(conv_code), .spi_active(spi_active),
      .spi_sck(spi_sck), .spi_cs_n(spi_cs_n), .spi_sdi(spi_sdi), .spi_sdo(spi_sdo));
   gcwf_host i_gcwf_host (.clk(clk), .reset_n(reset_n), .lnk(lnk), .psel(psel),
      .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
      .prdata(prdata), .pready(pready), .pslverr(pslverr), .irq(irq));
   gcwf_asserts i_gcwf_asserts (.clk(clk), .reset_n(reset_n), .pin_lvl(lnk.pin_lvl),
      .dev_o(lnk.dev_o), .dev_oe(lnk.dev_oe), .serial_port_select(lnk.serial_port_select),
      .reg_req(lnk.reg_req), .reg_ack(lnk.reg_ack));

   always #20 clk = ~clk;

   // Hang guard well above the longest expected run
   always @(posedge clk) begin
      cyc++;
      if (cyc == 20000) begin
         error_cnt++;
         report_and_stop();
      end
   end

   // ==========================================================
   // Tasks
   task report_and_stop();
      $display("checks %0d errors %0d", total_checks, error_cnt);
      if (error_cnt == 0 && total_checks > 0) begin
         $display("bench passed");
      end else begin
         $display("bench failed");
      end
      $finish;
   endtask

   task chk(input logic [31:0] got, input logic [31:0] exp);
      total_checks++;
      if (got !== exp) begin
         error_cnt++;
         $display("ERROR %0t: got %h expected %h", $time, got, exp);
      end
   endtask

   // One APB transfer; result left in rd and err
   task apb(input logic w, input logic [11:0] a, input logic [31:0] d);
      @(posedge clk);
      psel <= 1'h1;
      pwrite <= w;
      paddr <= a;
      pwdata <= d;
      @(posedge clk);
      penable <= 1'h1;
      // Wait for the slave; only the cycle guard ends a hang
      do begin
         @(posedge clk);
      end while (pready !== 1'h1);
      rd = prdata;
      err = pslverr;
      psel <= 1'h0;
      penable <= 1'h0;
   endtask

   task wr(input logic [11:0] a, input logic [31:0] d);
      apb(1'h1, a, d);
   endtask

   // Device register access through the host; answer in rd
   task dev(input logic w, input logic [3:0] i, input logic [31:0] d);
      wr(HREG_DEV_ADDR, {28'h0, i});
      wr(HREG_DEV_WDATA, d);
      wr(HREG_DEV_CMD, {30'h0, w, 1'h1});
      do begin
         apb(1'h0, HREG_DEV_CMD, 32'h0);
      end while (rd[0] !== 1'h0);
      apb(1'h0, HREG_DEV_RDATA, 32'h0);
   endtask

   task slp(input logic s, input logic t);
      @(posedge clk);
      sleep_command <= s;
      comm_timeout <= t;
      @(posedge clk);
      sleep_command <= 1'h0;
      comm_timeout <= 1'h0;
      repeat (3) @(posedge clk);
   endtask

   task conv(input logic [2:0] p, input logic [15:0] c);
      @(posedge clk);
      conv_valid <= 1'h1;
      conv_pin <= p;
      conv_code <= c;
      @(posedge clk);
      conv_valid <= 1'h0;
   endtask

   // ==========================================================
   // Scenarios
   initial begin
      repeat (20) @(posedge clk);
      reset_n <= 1'h1;
      dev(1'h0, DREG_CFG, 32'h0);
      chk(rd, {14'h0, CFG_RESET});
      chk({25'h0, conv_mask}, 32'h6f);
      apb(1'h0, 12'h02c, 32'h0);
      chk({31'h0, err}, 32'h1);
      // All off, yet pins 1 and 2 stay locked
      dev(1'h1, DREG_CFG, 32'h3ffff);
      dev(1'h0, DREG_CFG, 32'h0);
      chk(rd, 32'h3fff6);
      chk({25'h0, conv_mask}, 32'h0);
      // Pin 3 out, pin 4 in, pin 7 in
      dev(1'h1, DREG_CFG, 32'h2096);
      dev(1'h1, DREG_OUT, 32'h4);
      wr(HREG_EXT_OUT, 32'h8);
      wr(HREG_EXT_OE, 32'h8);
      dev(1'h0, DREG_IN, 32'h0);
      chk(rd & 32'hc, 32'hc);
      chk({23'h0, lnk.dev_oe}, 32'h6);
      // Fault relay, interrupt raise, mask, clear
      wr(HREG_IRQ_CLR, 32'h3);
      wr(HREG_IRQ_EN, 32'h1);
      wr(HREG_EXT_OUT, 32'h9);
      wr(HREG_EXT_OE, 32'h9);
      repeat (10) @(posedge clk);
      chk({31'h0, lnk.dev_o[1]}, 32'h1);
      chk({31'h0, irq}, 32'h1);
      wr(HREG_IRQ_EN, 32'h0);
      repeat (2) @(posedge clk);
      chk({31'h0, irq}, 32'h0);
      wr(HREG_IRQ_CLR, 32'h1);
      wr(HREG_IRQ_EN, 32'h1);
      apb(1'h0, HREG_IRQ_STAT, 32'h0);
      chk(rd & 32'h1, 32'h0);
      chk({31'h0, irq}, 32'h0);
      wr(HREG_EXT_OE, 32'h8);
      // Released upstream line clears the relay; local fault raises it alone
      repeat (4) @(posedge clk);
      chk({31'h0, lnk.dev_o[1]}, 32'h0);
      local_fault <= 1'h1;
      repeat (2) @(posedge clk);
      chk({31'h0, lnk.dev_o[1]}, 32'h1);
      local_fault <= 1'h0;
      // Sleep, filtered wake, sleep blocked while pin 7 high
      dev(1'h1, DREG_CTRL, 32'h1);
      slp(1'h1, 1'h0);
      chk({31'h0, low_power}, 32'h1);
      wr(HREG_EXT_OUT, 32'h48);
      wr(HREG_EXT_OE, 32'h48);
      repeat (WAKE_FILTER_CYC - 20) @(posedge clk);
      chk({31'h0, low_power}, 32'h1);
      repeat (40) @(posedge clk);
      chk({31'h0, low_power}, 32'h0);
      dev(1'h0, DREG_STAT, 32'h0);
      chk(rd, 32'h4);
      slp(1'h1, 1'h0);
      slp(1'h0, 1'h1);
      chk({31'h0, low_power}, 32'h0);
      wr(HREG_EXT_OE, 32'h8);
      repeat (4) @(posedge clk);
      slp(1'h0, 1'h1);
      chk({31'h0, low_power}, 32'h1);
      // No wake without the enable bit
      dev(1'h1, DREG_CTRL, 32'h0);
      wr(HREG_EXT_OE, 32'h48);
      repeat (WAKE_FILTER_CYC + 20) @(posedge clk);
      chk({31'h0, low_power}, 32'h1);
      dev(1'h1, DREG_CTRL, 32'h1);
      repeat (WAKE_FILTER_CYC + 20) @(posedge clk);
      chk({31'h0, low_power}, 32'h0);
      wr(HREG_EXT_OE, 32'h8);
      // Absolute then ratio result; digital pin ignored
      conv(3'h2, 16'h0100);
      dev(1'h0, 4'ha, 32'h0);
      chk(rd, 32'(256 * ABS_LSB_UV));
      dev(1'h1, DREG_CTRL, 32'h3);
      conv(3'h2, 16'h1234);
      dev(1'h0, 4'ha, 32'h0);
      chk(rd, {1'h1, 15'h0, 16'h1234});
      conv(3'h0, 16'hffff);
      dev(1'h0, DREG_RES0, 32'h0);
      chk(rd, 32'h0);
      // Serial port select routes and locks pins 8 and 9
      wr(HREG_EXT_OUT, 32'h88);
      wr(HREG_EXT_OE, 32'h88);
      spi_sdo <= 1'h1;
      wr(HREG_STRAP, 32'h5);
      repeat (6) @(posedge clk);
      chk({28'h0, spi_active, spi_cs_n, spi_sdi, spi_sck}, 32'hb);
      chk({31'h0, lnk.pin_lvl[8]}, 32'h1);
      dev(1'h0, DREG_CFG, 32'h0);
      chk(rd, 32'h1a096);
      spi_sdo <= 1'h0;
      repeat (4) @(posedge clk);
      chk({31'h0, lnk.pin_lvl[8]}, 32'h0);
      // Sticky fault and access-done events, level interrupt, pin snapshot
      apb(1'h0, HREG_IRQ_STAT, 32'h0);
      chk(rd, 32'h3);
      chk({31'h0, irq}, 32'h1);
      apb(1'h0, HREG_PINS, 32'h0);
      chk(rd, 32'h8c);
      report_and_stop();
   end
endmodule
`default_nettype wire
